/* common/bsap_defines.vh */
// Purpose: Shared constants of the burst SRAM access port
// Assumes: K and K# arrive as levels sampled on the system clock
// Notes:   Read latency is counted in half-cycle clock events

`ifndef BSAP_DEFINES_VH
`define BSAP_DEFINES_VH

// Byte lane geometry
`define BSAP_LANE_W          9
`define BSAP_LANES_DEFAULT   4

// Read pipeline, in half-cycle events after the command edge
`define BSAP_RD_STAGES       6
`define BSAP_RD_BEAT0_STAGE  4
`define BSAP_RD_BEAT1_STAGE  5

// Write buffer
`define BSAP_FIFO_DEPTH      4

// Reset values
`define BSAP_CLK_IDLE_LEVEL  1'b1
`define BSAP_OE_N_RESET      1'b1

`endif

/* core/bsap_fifo.v */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come from an occupancy count
`default_nettype none

module bsap_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter PTR_W = 2
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst,
	// Fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// Drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);

	localparam [PTR_W-1:0] PTR_ONE = 1;
	localparam [PTR_W:0]   CNT_ONE = 1;

	reg [WIDTH-1:0] store_reg [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_reg;
	reg [PTR_W-1:0] rd_ptr_reg;
	reg [PTR_W:0]   count_reg;
	wire            push;
	wire            pop;

	assign o_in_ready  = (count_reg != DEPTH[PTR_W:0]);
	assign o_out_valid = (count_reg != {(PTR_W+1){1'b0}});
	assign o_out_data  = store_reg[rd_ptr_reg];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always @(posedge i_clk) begin
		if (push) begin
			store_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	always @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr_reg <= {PTR_W{1'b0}};
			rd_ptr_reg <= {PTR_W{1'b0}};
			count_reg  <= {(PTR_W+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + CNT_ONE;
			end else if (pop & ~push) begin
				count_reg <= count_reg - CNT_ONE;
			end
		end
	end

endmodule

`default_nettype wire

/* core/bsap_lane_merge.v */
// Purpose: Merge one write beat into a stored word by byte lane
// Assumes: Lane enables are active low
// Notes:   Purely combinational
`default_nettype none

module bsap_lane_merge #(
	parameter LANES  = 4,
	parameter LANE_W = 9
) (
	// Operands
	input  wire [LANES*LANE_W-1:0] i_old,
	input  wire [LANES*LANE_W-1:0] i_new,
	input  wire [LANES-1:0]        i_lane_en_n,
	// Result
	output wire [LANES*LANE_W-1:0] o_merged
);

	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			// High select keeps the stored byte
			assign o_merged[g*LANE_W +: LANE_W] = i_lane_en_n[g] ?
				i_old[g*LANE_W +: LANE_W] : i_new[g*LANE_W +: LANE_W];
		end
	endgenerate

endmodule

`default_nettype wire

/* core/bsap_top.v */
// Purpose: Command, write and read data path of a two-beat burst SRAM
// Assumes: K and K# pins are levels synchronous to I_REF_CLK, sampled here
// Notes:   Reads do not see beats still waiting in the write buffer
`default_nettype none
`include "bsap_defines.vh"

module bsap_top #(
	parameter LANES  = `BSAP_LANES_DEFAULT,
	parameter ADDR_W = 8
) (
	// System
	input  wire                        I_REF_CLK,
	input  wire                        I_SYS_RST,
	// Memory clocks as levels
	input  wire                        I_K,
	input  wire                        I_K_N,
	// Command
	input  wire                        I_LOAD_STROBE_N,
	input  wire                        I_READ_NOT_WRITE,
	input  wire [ADDR_W-1:0]           I_ADDR,
	// Write data and lane selects
	input  wire [LANES*`BSAP_LANE_W-1:0] I_DQ,
	input  wire [LANES-1:0]            I_BYTE_LANE_ENABLE_N,
	// Read data
	output wire [LANES*`BSAP_LANE_W-1:0] O_DQ,
	output wire                        O_DQ_OE_N,
	// Write buffer status
	output wire                        O_WRITE_STALL
);

	////////////////////////////////////////////////////////////////////////
	// Local sizes

	localparam DW    = LANES * `BSAP_LANE_W;
	localparam IW    = ADDR_W + 1;
	localparam FW    = IW + LANES + DW;
	localparam WORDS = 1 << IW;
	localparam RDS   = `BSAP_RD_STAGES;
	localparam B0    = `BSAP_RD_BEAT0_STAGE;
	localparam B1    = `BSAP_RD_BEAT1_STAGE;

	////////////////////////////////////////////////////////////////////////
	// Declarations

	// Array, one entry per burst beat
	reg  [DW-1:0]     mem_reg [0:WORDS-1];

	// Clock edge detection
	reg               k_prev_reg;
	reg               kn_prev_reg;
	wire              k_rise;
	wire              kn_rise;
	wire              edge_evt;

	// Decoded commands
	wire              rd_cmd;
	wire              wr_cmd;

	// Write burst tracking
	reg               wr_a_vld_reg;
	reg  [ADDR_W-1:0] wr_a_addr_reg;
	reg               wr_b_vld_reg;
	reg  [ADDR_W-1:0] wr_b_addr_reg;
	wire              beat0_take;
	wire              beat1_take;
	wire              beat_masked;
	reg  [IW-1:0]     beat_idx;

	// Read pipeline
	reg  [RDS-1:0]    rd_vld_reg;
	reg  [ADDR_W-1:0] rd_addr_reg [0:RDS-1];
	wire              launch0;
	wire              launch1;
	wire              launch;
	reg  [IW-1:0]     launch_idx;

	// Output registers
	reg  [DW-1:0]     dq_reg;
	reg               dq_oe_n_reg;
	reg               stall_reg;

	// Write buffer
	wire              fifo_in_valid;
	wire              fifo_in_ready;
	wire [FW-1:0]     fifo_in_data;
	wire              fifo_out_valid;
	wire              fifo_out_ready;
	wire [FW-1:0]     fifo_out_data;
	wire [IW-1:0]     drain_idx;
	wire [LANES-1:0]  drain_lane_n;
	wire [DW-1:0]     drain_data;
	wire [DW-1:0]     merged;
	wire              drain;

	integer           s;

	////////////////////////////////////////////////////////////////////////
	// Clock edges and command decode

	// Idle level high keeps a parked clock from looking like a rise
	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			k_prev_reg  <= `BSAP_CLK_IDLE_LEVEL;
			kn_prev_reg <= `BSAP_CLK_IDLE_LEVEL;
		end else begin
			k_prev_reg  <= I_K;
			kn_prev_reg <= I_K_N;
		end
	end

	assign k_rise   = I_K & ~k_prev_reg;
	assign kn_rise  = I_K_N & ~kn_prev_reg;
	assign edge_evt = k_rise | kn_rise;

	// Commands only on K; a high strobe is an idle cycle
	assign rd_cmd = k_rise & ~I_LOAD_STROBE_N & I_READ_NOT_WRITE;
	assign wr_cmd = k_rise & ~I_LOAD_STROBE_N & ~I_READ_NOT_WRITE;

	////////////////////////////////////////////////////////////////////////
	// Write bursts

	// Beat A on the next K rise, beat A+1 on the K# rise after it
	assign beat0_take = k_rise & wr_a_vld_reg;
	assign beat1_take = kn_rise & wr_b_vld_reg;

	// A fully masked beat changes nothing, so it is not queued
	assign beat_masked = &I_BYTE_LANE_ENABLE_N;

	always @* begin
		beat_idx = {wr_b_addr_reg, 1'b1};
		if (beat0_take) begin
			beat_idx = {wr_a_addr_reg, 1'b0};
		end
	end

	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			wr_a_vld_reg  <= 1'b0;
			wr_a_addr_reg <= {ADDR_W{1'b0}};
			wr_b_vld_reg  <= 1'b0;
			wr_b_addr_reg <= {ADDR_W{1'b0}};
		end else begin
			// Clear first so a new beat A+1 wins a same-cycle collision
			if (beat1_take) begin
				wr_b_vld_reg <= 1'b0;
			end
			if (k_rise) begin
				// Back-to-back writes overlap: new address while beat A lands
				wr_a_vld_reg <= wr_cmd;
				if (wr_cmd) begin
					wr_a_addr_reg <= I_ADDR;
				end
				if (wr_a_vld_reg) begin
					wr_b_vld_reg  <= 1'b1;
					wr_b_addr_reg <= wr_a_addr_reg;
				end
			end
		end
	end

	// Lane selects travel with each beat, so masks may differ per beat
	assign fifo_in_valid = (beat0_take | beat1_take) & ~beat_masked;
	assign fifo_in_data  = {beat_idx, I_BYTE_LANE_ENABLE_N, I_DQ};

	////////////////////////////////////////////////////////////////////////
	// Write buffer and array update

	bsap_fifo #(
		.WIDTH (FW),
		.DEPTH (`BSAP_FIFO_DEPTH),
		.PTR_W (2)
	) u_wr_fifo (
		.i_clk       (I_REF_CLK),
		.i_rst       (I_SYS_RST),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in_data),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_out_ready),
		.o_out_data  (fifo_out_data)
	);

	assign drain_idx    = fifo_out_data[FW-1 -: IW];
	assign drain_lane_n = fifo_out_data[DW +: LANES];
	assign drain_data   = fifo_out_data[DW-1:0];

	// One array port: a read launch wins and the drain waits a cycle
	assign fifo_out_ready = ~launch;
	assign drain          = fifo_out_valid & fifo_out_ready;

	bsap_lane_merge #(
		.LANES  (LANES),
		.LANE_W (`BSAP_LANE_W)
	) u_merge (
		.i_old       (mem_reg[drain_idx]),
		.i_new       (drain_data),
		.i_lane_en_n (drain_lane_n),
		.o_merged    (merged)
	);

	always @(posedge I_REF_CLK) begin
		if (drain) begin
			mem_reg[drain_idx] <= merged;
		end
	end

	// Registered view of buffer back-pressure
	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			stall_reg <= 1'b0;
		end else begin
			stall_reg <= ~fifo_in_ready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read pipeline

	// Every half-cycle event advances it; stopped clocks freeze it
	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			rd_vld_reg <= {RDS{1'b0}};
			for (s = 0; s < RDS; s = s + 1) begin
				rd_addr_reg[s] <= {ADDR_W{1'b0}};
			end
		end else if (edge_evt) begin
			rd_vld_reg <= {rd_vld_reg[RDS-2:0], rd_cmd};
			rd_addr_reg[0] <= I_ADDR;
			for (s = 1; s < RDS; s = s + 1) begin
				rd_addr_reg[s] <= rd_addr_reg[s-1];
			end
		end
	end

	// Beat A at the third K# rise, beat A+1 at the K rise after it
	assign launch0 = kn_rise & rd_vld_reg[B0];
	assign launch1 = k_rise & rd_vld_reg[B1];
	assign launch  = launch0 | launch1;

	always @* begin
		launch_idx = {rd_addr_reg[B1], 1'b1};
		if (launch0) begin
			launch_idx = {rd_addr_reg[B0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data outputs

	// Each read runs to completion; the bus floats at the K# rise after
	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			dq_reg      <= {DW{1'b0}};
			dq_oe_n_reg <= `BSAP_OE_N_RESET;
		end else if (launch) begin
			dq_reg      <= mem_reg[launch_idx];
			dq_oe_n_reg <= 1'b0;
		end else if (kn_rise) begin
			dq_oe_n_reg <= 1'b1;
		end
	end

	// Read outputs change only at edges; a stopped clock holds O_DQ and O_DQ_OE_N, not O_WRITE_STALL
	assign O_DQ          = dq_reg;
	assign O_DQ_OE_N     = dq_oe_n_reg;
	assign O_WRITE_STALL = stall_reg;

endmodule

`default_nettype wire

/* tb/bsap_ctrl_model.sv */
// Purpose: Controller-side clock source for the memory K and K# pins
// Assumes: Four reference cycles per K period
// Notes:   Phase tells the bench where the next sampled level sits
`default_nettype none
module bsap_ctrl_model (
	// System
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_run,
	// Memory clocks
	output logic            o_k,
	output logic            o_k_n,
	output logic [1:0]      o_phase
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] phase_reg;
	logic       run_reg;
	always @(posedge i_clk) begin
		run_reg <= i_run & ~i_rst;
		if (i_rst)
			phase_reg <= 2'h2;
		else if (i_run)
			phase_reg <= phase_reg + 2'h1;
	end
	// Parked high while stopped so restart needs no charge balancing
	assign o_k = run_reg ? ~phase_reg[1] : 1'b1;
	assign o_k_n = run_reg ? phase_reg[1] : 1'b1;
	assign o_phase = phase_reg;
endmodule
`default_nettype wire

/* tb/bsap_top_asserts.sv */
// Purpose: Port-level timing checks of the burst SRAM access port
// Assumes: K period of four reference cycles, K# rising half a period after K
// Notes:   Read figures count reference edges from the command edge
`default_nettype none
`include "bsap_defines.vh"
module bsap_top_asserts #(
	parameter LANES  = 4,
	parameter ADDR_W = 8
) (
	// System
	input wire logic                          I_REF_CLK,
	input wire logic                          I_SYS_RST,
	input wire logic                          I_K,
	input wire logic                          I_K_N,
	// Command and data
	input wire logic                          I_LOAD_STROBE_N,
	input wire logic                          I_READ_NOT_WRITE,
	input wire logic [ADDR_W-1:0]             I_ADDR,
	input wire logic [LANES*`BSAP_LANE_W-1:0] I_DQ,
	input wire logic [LANES-1:0]              I_BYTE_LANE_ENABLE_N,
	input wire logic [LANES*`BSAP_LANE_W-1:0] O_DQ,
	input wire logic                          O_DQ_OE_N,
	input wire logic                          O_WRITE_STALL
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);
	////////////////////////////////////////////////////////////////////////////
	logic       k_q;
	logic       kn_q;
	logic [4:0] rd_age;
	wire        k_rise = I_K & ~k_q;
	wire        kn_rise = I_K_N & ~kn_q;
	wire        rd_cmd = k_rise & ~I_LOAD_STROBE_N & I_READ_NOT_WRITE;
	wire        wr_cmd = k_rise & ~I_LOAD_STROBE_N & ~I_READ_NOT_WRITE;
	// Age saturates so a long idle span never wraps back into a read window
	always @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			k_q <= 1'b1;
			kn_q <= 1'b1;
			rd_age <= 5'h1f;
		end else begin
			k_q <= I_K;
			kn_q <= I_K_N;
			if (rd_cmd)
				rd_age <= 5'h00;
			else if (rd_age != 5'h1f)
				rd_age <= rd_age + 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_rd_cmd;
		rd_cmd;
	endsequence
	sequence s_drive;
		(!O_DQ_OE_N) [*4];
	endsequence
	a_reset_deselect: assert property ($fell(I_SYS_RST) |-> O_DQ_OE_N && O_DQ == '0 && !O_WRITE_STALL)
		else $error("port not deselected after reset");
	a_read_window: assert property (s_rd_cmd |-> ##11 s_drive)
		else $error("read beats not driven at the expected edges");
	a_read_early: assert property (rd_cmd && rd_age >= 5'd7 |-> ##10 O_DQ_OE_N)
		else $error("read data driven too early");
	a_idle_float: assert property (rd_age >= 5'd15 |-> O_DQ_OE_N)
		else $error("output driven without a pending read");
	a_write_silent: assert property (wr_cmd && rd_age >= 5'd15 |-> ##1 O_DQ_OE_N [*8])
		else $error("write command drove the data output");
	a_dq_on_edges: assert property ($changed(O_DQ) |-> $past(k_rise) || $past(kn_rise))
		else $error("read data moved without a clock rise");
	a_oe_on_kn: assert property ($changed(O_DQ_OE_N) |-> $past(kn_rise) || $past(I_SYS_RST))
		else $error("output enable moved off a K# rise");
	a_dq_when_driven: assert property ($changed(O_DQ) |-> !O_DQ_OE_N || $past(I_SYS_RST))
		else $error("read data moved while floating");
endmodule
bind bsap_top bsap_top_asserts #(.LANES(LANES), .ADDR_W(ADDR_W)) bsap_top_asserts_inst (
	.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST), .I_K(I_K), .I_K_N(I_K_N),
	.I_LOAD_STROBE_N(I_LOAD_STROBE_N), .I_READ_NOT_WRITE(I_READ_NOT_WRITE), .I_ADDR(I_ADDR),
	.I_DQ(I_DQ), .I_BYTE_LANE_ENABLE_N(I_BYTE_LANE_ENABLE_N), .O_DQ(O_DQ),
	.O_DQ_OE_N(O_DQ_OE_N), .O_WRITE_STALL(O_WRITE_STALL));
`default_nettype wire

/* tb/bsap_top_bench.sv */
// Purpose: Self-checking bench for the burst SRAM access port
// Assumes: Controller model gives a K period of four reference cycles
// Notes:   Expected words come from a bench-side copy of the array
`default_nettype none
module bsap_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        run = 1'b0;
	logic        ld_n = 1'b1;
	logic        rnw = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [35:0] dq = 36'h0;
	logic [3:0]  be_n = 4'hf;
	wire  [35:0] q;
	wire         oe_n, stall, k, kn;
	wire  [1:0]  ph;
	integer      seed = 24;
	integer      fail_count = 0;
	integer      comparisons = 0;
	logic [35:0] mem [0:511];
	logic [7:0]  ra [0:9];
	bsap_top bsap_top_inst (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_K(k), .I_K_N(kn),
		.I_LOAD_STROBE_N(ld_n), .I_READ_NOT_WRITE(rnw), .I_ADDR(addr), .I_DQ(dq),
		.I_BYTE_LANE_ENABLE_N(be_n), .O_DQ(q), .O_DQ_OE_N(oe_n), .O_WRITE_STALL(stall));
	bsap_ctrl_model bsap_ctrl_model_inst (.i_clk(clk), .i_rst(rst), .i_run(run), .o_k(k),
		.o_k_n(kn), .o_phase(ph));
	initial forever #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task close_out;
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task cmp_dq(input logic [35:0] got, input logic [35:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [35:0] rnd36();
		logic [63:0] t;
		t = {$random(seed), $random(seed)};
		return t[35:0];
	endfunction
	function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
		input logic [3:0] e);
		for (int i = 0; i < 4; i++)
			if (!e[i])
				o[9*i +: 9] = n[9*i +: 9];
		return o;
	endfunction
	function automatic logic [3:0] lane(input int c);
		return (c < 4) ? ~(4'h1 << c) : 4'hf;
	endfunction
	task cyc;
		@(posedge clk);
		#1;
	endtask
	task to_ph(input logic [1:0] p);
		cyc;
		while (ph !== p)
			cyc;
	endtask
	// Lines outside a transfer carry junk, never the last value
	task scramble;
		logic [31:0] r;
		r = $random(seed);
		dq = rnd36();
		be_n = r[3:0];
		addr = r[11:4];
		rnw = r[12];
	endtask
	task cmd(input logic r, input logic [7:0] a);
		ld_n = 1'b0;
		rnw = r;
		addr = a;
		cyc;
		ld_n = 1'b1;
		scramble;
	endtask
	task wr(input logic [7:0] a, input logic [35:0] d0, input logic [35:0] d1,
		input logic [3:0] e0, input logic [3:0] e1);
		to_ph(2'h0);
		cmd(1'b0, a);
		to_ph(2'h0);
		dq = d0;
		be_n = e0;
		cyc;
		scramble;
		to_ph(2'h2);
		dq = d1;
		be_n = e1;
		cyc;
		scramble;
		mem[{a, 1'b0}] = mrg(mem[{a, 1'b0}], d0, e0);
		mem[{a, 1'b1}] = mrg(mem[{a, 1'b1}], d1, e1);
	endtask
	// Back-to-back reads, checker runs beside the issuer
	task rd_all;
		to_ph(2'h3);
		fork
			for (int i = 0; i < 10; i++) begin
				to_ph(2'h0);
				cmd(1'b1, ra[i]);
			end
			begin
				repeat (13) cyc;
				for (int i = 0; i < 10; i++) begin
					cmp_dq(q, mem[{ra[i], 1'b0}]);
					cmp_bit(oe_n, 1'b0);
					repeat (2) cyc;
					cmp_dq(q, mem[{ra[i], 1'b1}]);
					repeat (2) cyc;
				end
				cmp_bit(oe_n, 1'b1);
			end
		join
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		cyc;
		cmp_bit(oe_n, 1'b1);
		cmp_dq(q, 36'h0);
		cmp_bit(stall, 1'b0);
		run = 1'b1;
		repeat (12) begin
			cyc;
			scramble;
			cmp_bit(oe_n, 1'b1);
		end
		for (int p = 0; p < 2; p++) begin
			for (int a = 0; a < 8; a++)
				wr(a[7:0], rnd36(), rnd36(), 4'h0, 4'h0);
			for (int c = 0; c < 5; c++)
				wr(c[7:0], rnd36(), rnd36(), lane(c), lane((c + 1) % 5));
			repeat (16) begin
				r = $random(seed);
				wr({5'h0, r[2:0]}, rnd36(), rnd36(), r[7:4], r[11:8]);
			end
			for (int i = 0; i < 10; i++) begin
				r = $random(seed);
				ra[i] = {5'h0, r[2:0]};
			end
			rd_all;
			// Turnaround gap keeps reads and writes off the bus together
			repeat (12) cyc;
		end
		close_out;
	end
	initial begin
		#40000;
		fail_count = fail_count + 1;
		close_out;
	end
endmodule
`default_nettype wire
